// file: hdl/egr_regs.svh
// Register offsets, field positions, reset values and timing counts of the gear ratio block.
`ifndef EGR_REGS_SVH
`define EGR_REGS_SVH

// ==========================================================================
// Register word offsets (byte address bits 5:2)
// ==========================================================================
`define EGR_OFS_OVERRIDE   4'h0
`define EGR_OFS_ENC_RES    4'h1
`define EGR_OFS_GEAR_NUM   4'h2
`define EGR_OFS_GEAR_DEN   4'h3
`define EGR_OFS_FEED       4'h4
`define EGR_OFS_CMD        4'h5
`define EGR_OFS_LAST       4'h6
`define EGR_OFS_POS        4'h7
`define EGR_OFS_REM        4'h8
`define EGR_OFS_RATIO_NUM  4'h9
`define EGR_OFS_RATIO_DEN  4'ha
`define EGR_OFS_CTRL       4'hb
`define EGR_OFS_STATUS     4'hc

// ==========================================================================
// Field positions
// ==========================================================================
`define EGR_CTRL_RESTART   0
`define EGR_STAT_BUSY      0
`define EGR_STAT_SRC_LO    1
`define EGR_STAT_SRC_HI    2

// ==========================================================================
// Reset values and fixed figures
// ==========================================================================
`define EGR_ENC_COUNTS     32'h0080_0000
`define EGR_RST_OVERRIDE   32'h0000_0000
`define EGR_RST_GEAR_NUM   32'h0000_0001
`define EGR_RST_GEAR_DEN   32'h0000_0001
`define EGR_RST_FEED       32'h0000_2710
`define EGR_DIV_STEPS      7'h40

`endif

// file: hdl/egr_pkg.sv
// Types shared by the gear ratio block and its divider.
package egr_pkg;

  // ========================================================================
  // Enumerations
  // ========================================================================
  typedef enum logic [1:0] {
    EGR_SRC_OVERRIDE,
    EGR_SRC_FEED,
    EGR_SRC_GEAR
  } egr_src_t;

  typedef enum logic [1:0] {
    EGR_ST_IDLE,
    EGR_ST_START,
    EGR_ST_DIV
  } egr_state_t;

  typedef enum logic {
    EGR_DV_IDLE,
    EGR_DV_RUN
  } egr_dv_state_t;

endpackage

// file: hdl/egr_divider.sv
// Sequential unsigned divider, 64-bit dividend by 32-bit divisor, one quotient bit a cycle.
`timescale 1ns/1ps
`include "egr_regs.svh"

module egr_divider
  import egr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic [63:0] dividend_i,
  input  wire logic [31:0] divisor_i,
  output logic             done_o,
  output logic [63:0]      quo_o,
  output logic [31:0]      rem_o
);

  typedef struct packed {
    egr_dv_state_t st;
    logic [32:0]   rem;
    logic [63:0]   quo;
    logic [31:0]   dvs;
    logic [6:0]    cnt;
    logic          done;
  } egr_dv_t;

  egr_dv_t dv_ff;
  egr_dv_t nxt_dv;

  // ==========================================================================
  // Restoring division step
  // ==========================================================================
  always_comb begin
    logic [32:0] trial;
    trial = 33'h0;
    nxt_dv = dv_ff;
    nxt_dv.done = 1'b0;
    case (dv_ff.st)
      EGR_DV_IDLE: begin
        if (start_i) begin
          nxt_dv.st  = EGR_DV_RUN;
          nxt_dv.rem = 33'h0;
          nxt_dv.quo = dividend_i;
          nxt_dv.dvs = divisor_i;
          nxt_dv.cnt = `EGR_DIV_STEPS;
        end
      end
      EGR_DV_RUN: begin
        trial = {dv_ff.rem[31:0], dv_ff.quo[63]};
        if (trial >= {1'b0, dv_ff.dvs}) begin
          nxt_dv.rem = trial - {1'b0, dv_ff.dvs};
          nxt_dv.quo = {dv_ff.quo[62:0], 1'b1};
        end else begin
          nxt_dv.rem = trial;
          nxt_dv.quo = {dv_ff.quo[62:0], 1'b0};
        end
        nxt_dv.cnt = dv_ff.cnt - 7'h1;
        if (dv_ff.cnt == 7'h1) begin
          nxt_dv.st   = EGR_DV_IDLE;
          nxt_dv.done = 1'b1;
        end
      end
      default: begin
        nxt_dv.st = EGR_DV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dv_ff <= '{st: EGR_DV_IDLE, rem: 33'h0, quo: 64'h0, dvs: 32'h0, cnt: 7'h0, done: 1'b0};
    end else begin
      dv_ff <= nxt_dv;
    end
  end

  assign done_o = dv_ff.done;
  assign quo_o  = dv_ff.quo;
  assign rem_o  = dv_ff.rem[31:0];

endmodule

// file: hdl/egr_gear_ratio.sv
// Electronic gear ratio selection and command scaling with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "egr_regs.svh"

// Behaviour
// - Ratio is encoder counts over command units; it scales commands into counts.
// - Nonzero override is used; zero override falls back to the feed constant path, or the gear numerator path when feed equals resolution.
// - A nonzero override beats gear numerator and feed constant; encoder resolution stays the numerator.
// - Encoder resolution is fixed at 23 bits, 8388608 counts a turn.
// - Feed constant unlike resolution gives ratio resolution over feed constant.
// - Feed constant equal to resolution gives ratio gear numerator over feed constant.
module egr_gear_ratio
  import egr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [31:0]      scaled_pos_o,
  output logic [31:0]      scaled_delta_o,
  output logic             scaled_valid_o
);

  typedef struct packed {
    logic [31:0] ovr;
    logic [31:0] gnum;
    logic [31:0] gden;
    logic [31:0] feed;
    logic [31:0] cmd;
    logic [31:0] t_num;
    logic [31:0] t_den;
    egr_src_t    src;
    logic [32:0] rem;
    logic [31:0] pos;
    logic [31:0] last;
    logic        neg;
    logic [63:0] mag;
    egr_state_t  st;
    logic        rd_valid;
    logic [31:0] rdata;
    logic        valid;
  } egr_state_s_t;

  egr_state_s_t s_ff;
  egr_state_s_t nxt_s;

  logic        div_done;
  logic [63:0] div_quo;
  logic [31:0] div_rem;
  logic [3:0]  reg_idx;
  logic        busy;
  logic        wr_stall;

  // ==========================================================================
  // Bus decode and handshake
  // ==========================================================================
  assign reg_idx  = avs_address_i[5:2];
  assign busy     = (s_ff.st != EGR_ST_IDLE);
  // Scaling starts and restarts wait while a division is in flight.
  assign wr_stall = avs_write_i && busy &&
                    ((reg_idx == `EGR_OFS_CMD) || (reg_idx == `EGR_OFS_CTRL));

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign avs_waitrequest_o = (avs_read_i && !s_ff.rd_valid) || wr_stall;
  assign avs_readdata_o    = s_ff.rdata;
  assign scaled_pos_o      = s_ff.pos;
  assign scaled_delta_o    = s_ff.last;
  assign scaled_valid_o    = s_ff.valid;

  // ==========================================================================
  // Byte lane merge
  // ==========================================================================
  function automatic logic [31:0] egr_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Ratio selection, bus access and scaling sequence
  // ==========================================================================
  always_comb begin
    logic signed [64:0] prod;
    logic [63:0]        q_sgn;
    logic [32:0]        r_sgn;
    prod  = 65'sh0;
    q_sgn = 64'h0;
    r_sgn = 33'h0;
    nxt_s = s_ff;
    nxt_s.valid = 1'b0;

    // Bus reads take one wait cycle so the answer comes from a flip-flop.
    nxt_s.rd_valid = avs_read_i && !s_ff.rd_valid;
    if (avs_read_i && !s_ff.rd_valid) begin
      case (reg_idx)
        `EGR_OFS_OVERRIDE:  nxt_s.rdata = s_ff.ovr;
        `EGR_OFS_ENC_RES:   nxt_s.rdata = `EGR_ENC_COUNTS;
        `EGR_OFS_GEAR_NUM:  nxt_s.rdata = s_ff.gnum;
        `EGR_OFS_GEAR_DEN:  nxt_s.rdata = s_ff.gden;
        `EGR_OFS_FEED:      nxt_s.rdata = s_ff.feed;
        `EGR_OFS_CMD:       nxt_s.rdata = s_ff.cmd;
        `EGR_OFS_LAST:      nxt_s.rdata = s_ff.last;
        `EGR_OFS_POS:       nxt_s.rdata = s_ff.pos;
        `EGR_OFS_REM:       nxt_s.rdata = s_ff.rem[31:0];
        `EGR_OFS_RATIO_NUM: nxt_s.rdata = s_ff.t_num;
        `EGR_OFS_RATIO_DEN: nxt_s.rdata = s_ff.t_den;
        `EGR_OFS_STATUS:    nxt_s.rdata = {29'h0, s_ff.src, busy};
        default:            nxt_s.rdata = 32'h0;
      endcase
    end

    if (avs_write_i && !wr_stall) begin
      case (reg_idx)
        `EGR_OFS_OVERRIDE: nxt_s.ovr  = egr_merge(s_ff.ovr, avs_writedata_i, avs_byteenable_i);
        `EGR_OFS_GEAR_NUM: nxt_s.gnum = egr_merge(s_ff.gnum, avs_writedata_i, avs_byteenable_i);
        `EGR_OFS_GEAR_DEN: nxt_s.gden = egr_merge(s_ff.gden, avs_writedata_i, avs_byteenable_i);
        `EGR_OFS_FEED:     nxt_s.feed = egr_merge(s_ff.feed, avs_writedata_i, avs_byteenable_i);
        `EGR_OFS_CMD: begin
          nxt_s.cmd = egr_merge(s_ff.cmd, avs_writedata_i, avs_byteenable_i);
          nxt_s.st  = EGR_ST_START;
        end
        `EGR_OFS_CTRL: begin
          // Restart: new settings take effect only here, as after power up.
          if (avs_byteenable_i[0] && avs_writedata_i[`EGR_CTRL_RESTART]) begin
            if (s_ff.ovr != 32'h0) begin
              nxt_s.t_num = `EGR_ENC_COUNTS;
              nxt_s.t_den = s_ff.ovr;
              nxt_s.src   = EGR_SRC_OVERRIDE;
            end else if (s_ff.feed != `EGR_ENC_COUNTS) begin
              nxt_s.t_num = `EGR_ENC_COUNTS;
              nxt_s.t_den = s_ff.feed;
              nxt_s.src   = EGR_SRC_FEED;
            end else begin
              nxt_s.t_num = s_ff.gnum;
              nxt_s.t_den = s_ff.feed;
              nxt_s.src   = EGR_SRC_GEAR;
            end
            nxt_s.rem  = 33'h0;
            nxt_s.pos  = 32'h0;
            nxt_s.last = 32'h0;
          end
        end
        default: begin
        end
      endcase
    end

    case (s_ff.st)
      EGR_ST_IDLE: begin
      end
      EGR_ST_START: begin
        // Counts = command * numerator + carried remainder, divided by denominator.
        prod = $signed(s_ff.cmd) * $signed({1'b0, s_ff.t_num}) + $signed(s_ff.rem);
        // Only the magnitude is divided; the sign is put back when the quotient returns.
        nxt_s.neg = prod[64];
        nxt_s.mag = prod[64] ? 64'(-prod) : prod[63:0];
        nxt_s.st  = EGR_ST_DIV;
      end
      EGR_ST_DIV: begin
        if (div_done) begin
          // Both results take the sign of the product, so division truncates toward zero.
          q_sgn = s_ff.neg ? (64'h0 - div_quo) : div_quo;
          r_sgn = s_ff.neg ? (33'h0 - {1'b0, div_rem}) : {1'b0, div_rem};
          nxt_s.rem   = r_sgn;
          nxt_s.last  = q_sgn[31:0];
          nxt_s.pos   = s_ff.pos + q_sgn[31:0];
          nxt_s.valid = 1'b1;
          nxt_s.st    = EGR_ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = EGR_ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      // Reset latches the terms that the default settings select.
      s_ff <= '{ovr: `EGR_RST_OVERRIDE, gnum: `EGR_RST_GEAR_NUM, gden: `EGR_RST_GEAR_DEN,
                feed: `EGR_RST_FEED, cmd: 32'h0, t_num: `EGR_ENC_COUNTS,
                t_den: `EGR_RST_FEED, src: EGR_SRC_FEED, rem: 33'h0, pos: 32'h0,
                last: 32'h0, neg: 1'b0, mag: 64'h0, st: EGR_ST_IDLE, rd_valid: 1'b0,
                rdata: 32'h0, valid: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Divider
  // ==========================================================================
  // The divisor comes from the latched terms, which cannot change while busy.
  egr_divider egr_divider_i (
    .mclk_i     (mclk_i),
    .srst_i     (srst_i),
    .start_i    (s_ff.st == EGR_ST_START),
    .dividend_i (nxt_s.mag),
    .divisor_i  (s_ff.t_den),
    .done_o     (div_done),
    .quo_o      (div_quo),
    .rem_o      (div_rem)
  );

endmodule

// file: tb/egr_gear_ratio_checker.sv
// Concurrent checks on the ports of the gear ratio block.
`timescale 1ns/1ps
`include "egr_regs.svh"

module egr_gear_ratio_checker (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [31:0] scaled_pos_o,
  input wire logic [31:0] scaled_delta_o,
  input wire logic        scaled_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire logic [3:0] widx   = avs_address_i[5:2];
  wire logic       rd_cap = avs_read_i && !avs_waitrequest_o;

  a_reset_clear: assert property ($fell(srst_i) |-> scaled_pos_o == 32'h0 && !scaled_valid_o)
    else $error("position or valid not cleared by reset");
  a_valid_pulse: assert property (scaled_valid_o |=> !scaled_valid_o)
    else $error("scaled valid longer than one cycle");
  a_pos_accum: assert property (scaled_valid_o |-> scaled_pos_o == $past(scaled_pos_o) + scaled_delta_o)
    else $error("position not advanced by delta");
  a_pos_hold: assert property (!scaled_valid_o && !$past(avs_write_i) |-> $stable(scaled_pos_o))
    else $error("position moved without a command");
  a_cmd_latency: assert property (avs_write_i && !avs_waitrequest_o && widx == 4'h5 |-> ##[60:80] scaled_valid_o)
    else $error("command not scaled in time");
  a_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait state count wrong");
  a_enc_const: assert property (rd_cap && widx == 4'h1 |-> avs_readdata_o == `EGR_ENC_COUNTS)
    else $error("encoder resolution read wrong");
  a_unmapped_zero: assert property (rd_cap && widx >= 4'hd |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind egr_gear_ratio egr_gear_ratio_checker egr_gear_ratio_checker_i (.mclk_i, .srst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .scaled_pos_o, .scaled_delta_o, .scaled_valid_o);

// file: tb/egr_host_model.sv
// Host controller model that writes and reads the block over Avalon-MM.
`timescale 1ns/1ps

module egr_host_model (
  input  wire logic  mclk_i,
  input  wire logic  avs_waitrequest_i,
  output logic [5:0]  avs_address_o,
  output logic        avs_read_o,
  output logic        avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0]  avs_byteenable_o
);
  initial begin
    avs_address_o = 6'h3f;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'hf;
  end

  // The request holds until waitrequest is seen low; released lines show inverted values.
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
    @(posedge mclk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    avs_read_o <= rd;
    avs_write_o <= !rd;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_i !== 1'b0);
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_address_o <= ~a;
    avs_writedata_o <= ~d;
    avs_byteenable_o <= ~be;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the gear ratio block.
`timescale 1ns/1ps
`include "egr_regs.svh"

module testbench;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [5:0]  avs_address_i;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o, scaled_valid_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, scaled_pos_o, scaled_delta_o;
  logic [3:0]  avs_byteenable_i;
  int          miscompares = 0;
  int          num_checks = 0;
  integer      seed = 32'h388416f6;
  logic [31:0] rd_q[$], sc_q[$], pos = 32'h0;
  longint      num = 8388608, den = 10000, rem = 0, p, q = 0;

  always #5 mclk_i = ~mclk_i;

  egr_gear_ratio egr_gear_ratio_i (.mclk_i, .srst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .scaled_pos_o, .scaled_delta_o, .scaled_valid_o);
  egr_host_model egr_host_model_i (.mclk_i, .avs_waitrequest_i(avs_waitrequest_o),
    .avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
    .avs_writedata_o(avs_writedata_i), .avs_byteenable_o(avs_byteenable_i));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_scaled(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: scaled got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Result watchers
  // ==========================================================================
  always @(posedge mclk_i) if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
    cmp(avs_readdata_o, rd_q.pop_front());
  end
  always @(posedge mclk_i) if (scaled_valid_o === 1'b1) begin
    cmp_scaled(scaled_delta_o, sc_q.pop_front());
    cmp_scaled(scaled_pos_o, sc_q.pop_front());
  end

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    egr_host_model_i.xfer(1'b1, a, 32'h0);
  endtask

  task automatic cmd(input logic [31:0] c);
    p = longint'($signed(c)) * num + rem;
    q = p / den;
    rem = p - q * den;
    pos += q[31:0];
    sc_q.push_back(q[31:0]);
    sc_q.push_back(pos);
    egr_host_model_i.xfer(1'b0, 6'h14, c);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] ov, fd, g, sv;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    egr_host_model_i.xfer(1'b0, 6'h04, 32'h0);
    rd(6'h04, `EGR_ENC_COUNTS);
    rd(6'h24, `EGR_ENC_COUNTS);
    rd(6'h28, 32'h0000_2710);
    rd(6'h30, 32'h0000_0002);
    rd(6'h34, 32'h0);
    egr_host_model_i.xfer(1'b0, 6'h0c, 32'hffff_ffff);
    egr_host_model_i.xfer(1'b0, 6'h0c, 32'h0000_0012, 4'h1);
    rd(6'h0c, 32'hffff_ff12);
    for (int i = 0; i < 3; i++) begin
      ov = (i == 0) ? 32'd1049 + ($random(seed) & 32'hffff) : 32'h0;
      fd = (i == 1) ? 32'd2000 + ($random(seed) & 32'hffff) : `EGR_ENC_COUNTS;
      g = 32'h1 + ($random(seed) & 32'h3ff);
      egr_host_model_i.xfer(1'b0, 6'h00, ov);
      egr_host_model_i.xfer(1'b0, 6'h10, fd);
      egr_host_model_i.xfer(1'b0, 6'h08, g);
      rd(6'h00, ov);
      rd(6'h10, fd);
      rd(6'h08, g);
      cmd($random(seed) % 3000);
      egr_host_model_i.xfer(1'b0, 6'h2c, 32'h1);
      rem = 0;
      pos = 32'h0;
      num = (ov != 0 || fd != `EGR_ENC_COUNTS) ? `EGR_ENC_COUNTS : g;
      den = (ov != 0) ? ov : fd;
      rd(6'h24, num[31:0]);
      rd(6'h28, den[31:0]);
      sv = (ov != 0) ? 32'h0 : (fd != `EGR_ENC_COUNTS) ? 32'h2 : 32'h4;
      rd(6'h30, sv);
      cmd($random(seed) % 3000);
      rd(6'h30, sv | 32'h1);
      repeat (2) cmd($random(seed) % 3000);
      while (sc_q.size() > 0) @(posedge mclk_i);
      rd(6'h18, q[31:0]);
      rd(6'h1c, pos);
      rd(6'h20, rem[31:0]);
    end
    repeat (2) @(posedge mclk_i);
    summarize;
  end

  initial begin
    #300000;
    miscompares++;
    summarize;
  end
endmodule
